// ---- fcr_bank.v ----
// front-end control register bank with serial port and lvds framer
`include "fcr_consts.vh"
`default_nettype none
module fcr_bank (
   input  wire        REF_CLK_I,       // 25 MHz clock
   input  wire        RST_N_I,         // async reset, active low
   input  wire        SPI_SCK_I,       // serial port clock
   input  wire        SPI_CS_N_I,      // serial port select, low
   input  wire        SPI_SDI_I,       // serial data in
   output reg         SPI_SDO_O,       // serial data out
   input  wire        TRACK_PIN_I,     // external tracking enable pin
   input  wire [5:0]  TRACK_CODE_I,    // tracking calibration code
   input  wire [95:0] ADC_DATA_I,      // 8 x 12-bit adc results
   output reg  [7:0]  ADC_PD_O,        // adc power down per channel
   output reg  [7:0]  FRONT_PD_O,      // lna+vga+filter power down
   output reg  [7:0]  LNA_ON_O,        // lna powered per channel
   output reg  [7:0]  GM_ON_O,         // transconductance amp on
   output reg         CW_SW_ON_O,      // cross-point switch powered
   output reg         PLL_EN_O,        // pll enable
   output reg         LVDS_EN_O,       // lvds drivers enable
   output reg  [2:0]  LVDS_SWING_O,    // lvds amplitude code
   output reg  [5:0]  CLK_DLY_O,       // frame and bit clock delay
   output reg  [5:0]  DATA_DLY_O,      // data lane delay
   output reg         FB_SWITCH_O,     // lna feedback switch closed
   output reg         PREAMP_GAIN_O,   // preamp gain select
   output reg  [1:0]  PGA_GAIN_O,      // pga gain field
   output reg         EXT_BIAS_O,      // external bias select
   output reg  [1:0]  TRACK_OFS_O,     // tracking offset
   output reg  [3:0]  TRACK_FINE_O,    // tracking fine code
   output reg         TRACK_ON_O,      // tracking engine running
   output reg         TRACK_LOCKED_O,  // lock time elapsed
   output reg  [5:0]  FILTER_CODE_O,   // filter corner code
   output reg         BIT_CLK_O,       // serial bit clock
   output reg         FRAME_CLK_O,     // frame clock
   output wire [7:0]  DOUT_O           // lvds data lanes
);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   wire [3:0] sync_q;
   wire       sck_s;
   wire       cs_n_s;
   wire       sdi_s;
   wire       pin_s;

   fcr_sync2 #(
      .W (4)
   ) u_sync (
      .clk_i   (REF_CLK_I),
      .rst_n_i (RST_N_I),
      .d_i     ({TRACK_PIN_I, SPI_SDI_I, ~SPI_CS_N_I, SPI_SCK_I}),
      .q_o     (sync_q)
   );

   assign sck_s  = sync_q[0];
   // select travels inverted so the synchroniser's reset value is idle
   assign cs_n_s = ~sync_q[1];
   assign sdi_s  = sync_q[2];
   assign pin_s  = sync_q[3];

   reg  sck_d_reg;
   wire sck_rise;
   wire sck_fall;

   always @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sck_d_reg <= 1'b0;
      end else begin
         sck_d_reg <= sck_s;
      end
   end

   assign sck_rise = sck_s & ~sck_d_reg;
   assign sck_fall = ~sck_s & sck_d_reg;

   // ----------------------------------------------------------------
   // register array
   // ----------------------------------------------------------------
   reg  [`FCR_DW-1:0] regs [0:15];
   wire [`FCR_DW-1:0] r_mode;
   wire [`FCR_DW-1:0] r_front;
   wire [`FCR_DW-1:0] r_filt;
   wire [`FCR_DW-1:0] r_rb;
   wire               cw_mode;

   assign r_mode  = regs[`FCR_A_MODE];
   assign r_front = regs[`FCR_A_FRONT];
   assign r_filt  = regs[`FCR_A_FILTER];
   assign r_rb    = regs[`FCR_A_RB_SEL];
   assign cw_mode = r_mode[`FCR_MODE_BIT];

   // ----------------------------------------------------------------
   // serial port state machine
   // ----------------------------------------------------------------
   localparam ST_IDLE  = 1'b0;
   localparam ST_SHIFT = 1'b1;

   reg        st_reg;
   reg        st_next;
   reg [4:0]  cnt_reg;
   reg [4:0]  cnt_next;
   reg [15:0] rx_reg;
   reg [15:0] rx_next;
   reg [15:0] tx_reg;
   reg [15:0] tx_next;
   reg        wr_next;
   reg [`FCR_DW-1:0] rb_word;

   // readback source is the register picked by the select field
   always @* begin
      rb_word = regs[r_rb[`FCR_RB_HI:`FCR_RB_LO]];
   end

   always @* begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      rx_next  = rx_reg;
      tx_next  = tx_reg;
      wr_next  = 1'b0;
      case (st_reg)
         ST_IDLE: begin
            if (!cs_n_s) begin
               st_next  = ST_SHIFT;
               cnt_next = 5'h00;
               tx_next  = {4'h0, rb_word};
            end
         end
         ST_SHIFT: begin
            if (cs_n_s) begin
               st_next = ST_IDLE;
            end else begin
               if (sck_rise && cnt_reg != `FCR_FRAME_BITS) begin
                  rx_next  = {rx_reg[14:0], sdi_s};
                  cnt_next = cnt_reg + 5'h01;
                  // bits past the sixteenth are ignored
                  if (cnt_reg == `FCR_FRAME_BITS - 5'h01) begin
                     wr_next = 1'b1;
                  end
               end
               if (sck_fall) begin
                  tx_next = {tx_reg[14:0], 1'b0};
               end
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
   end

   integer i;

   always @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_reg    <= ST_IDLE;
         cnt_reg   <= 5'h00;
         rx_reg    <= `FCR_SH_RESET;
         tx_reg    <= `FCR_SH_RESET;
         SPI_SDO_O <= 1'b0;
         for (i = 0; i < 16; i = i + 1) begin
            regs[i] <= `FCR_REG_RESET;
         end
      end else begin
         st_reg    <= st_next;
         cnt_reg   <= cnt_next;
         rx_reg    <= rx_next;
         tx_reg    <= tx_next;
         SPI_SDO_O <= tx_next[15];
         if (wr_next) begin
            regs[rx_next[15:12]] <= rx_next[11:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // power and mode decode
   // ----------------------------------------------------------------
   reg [7:0] cw_on;
   integer   k;

   // each switch register carries two channels, enables in bit 5 and bit 11
   always @* begin
      cw_on = 8'h00;
      for (k = 0; k < 4; k = k + 1) begin
         cw_on[2*k]   = regs[k + `FCR_A_CW_FIRST][`FCR_CW_ON_LO];
         cw_on[2*k+1] = regs[k + `FCR_A_CW_FIRST][`FCR_CW_ON_HI];
      end
   end

   always @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ADC_PD_O      <= 8'h00;
         FRONT_PD_O    <= 8'h00;
         LNA_ON_O      <= 8'hff;
         GM_ON_O       <= 8'h00;
         CW_SW_ON_O    <= 1'b0;
         PLL_EN_O      <= 1'b1;
         LVDS_EN_O     <= 1'b1;
         LVDS_SWING_O  <= 3'h0;
         CLK_DLY_O     <= 6'h00;
         DATA_DLY_O    <= 6'h00;
         FB_SWITCH_O   <= 1'b0;
         PREAMP_GAIN_O <= 1'b0;
         PGA_GAIN_O    <= 2'h0;
         EXT_BIAS_O    <= 1'b0;
         TRACK_OFS_O   <= 2'h0;
         TRACK_FINE_O  <= 4'h0;
      end else begin
         if (cw_mode) begin
            ADC_PD_O   <= 8'hff;
            FRONT_PD_O <= 8'hff;
            LNA_ON_O   <= cw_on;
            GM_ON_O    <= cw_on;
            CW_SW_ON_O <= |cw_on;
         end else begin
            // switch registers have no effect here
            ADC_PD_O   <= regs[`FCR_A_ADC_PD][7:0];
            FRONT_PD_O <= r_mode[7:0];
            LNA_ON_O   <= ~r_mode[7:0];
            GM_ON_O    <= 8'h00;
            CW_SW_ON_O <= 1'b0;
         end
         PLL_EN_O      <= ~cw_mode;
         LVDS_EN_O     <= ~cw_mode;
         LVDS_SWING_O  <= regs[`FCR_A_SWING][`FCR_SWING_HI:`FCR_SWING_LO];
         CLK_DLY_O     <= regs[`FCR_A_CLK_DLY][`FCR_DLY_HI:`FCR_DLY_LO];
         DATA_DLY_O    <= regs[`FCR_A_OUT_CTL][`FCR_DLY_HI:`FCR_DLY_LO];
         FB_SWITCH_O   <= r_front[`FCR_FBSW_BIT];
         PREAMP_GAIN_O <= r_front[`FCR_GAIN_BIT];
         PGA_GAIN_O    <= r_front[`FCR_PGA_HI:0];
         EXT_BIAS_O    <= r_front[`FCR_BIAS_BIT];
         TRACK_OFS_O   <= r_front[`FCR_OFS_HI:`FCR_OFS_LO];
         TRACK_FINE_O  <= r_filt[`FCR_FINE_HI:0];
      end
   end

   // ----------------------------------------------------------------
   // filter corner selection and tracking
   // ----------------------------------------------------------------
   wire        prog_sel;
   wire        track_run;
   reg  [10:0] lock_cnt_reg;

   assign prog_sel  = r_filt[`FCR_CTL_BIT];
   // tracking only matters while the filter is in use
   assign track_run = (r_front[`FCR_TRACK_BIT] | pin_s)
                      & ~prog_sel & ~cw_mode;

   always @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         FILTER_CODE_O  <= 6'h00;
         TRACK_ON_O     <= 1'b0;
         TRACK_LOCKED_O <= 1'b0;
         lock_cnt_reg   <= 11'h000;
      end else begin
         TRACK_ON_O <= track_run;
         if (prog_sel) begin
            FILTER_CODE_O <= {r_filt[`FCR_PR_HI:`FCR_PR_LO], 2'h0};
         end else if (track_run) begin
            FILTER_CODE_O <= TRACK_CODE_I;
         end
         // lock flag is a conservative timer, not a measured lock
         if (!track_run) begin
            lock_cnt_reg   <= 11'h000;
            TRACK_LOCKED_O <= 1'b0;
         end else if (lock_cnt_reg != `FCR_LOCK_CYC) begin
            lock_cnt_reg   <= lock_cnt_reg + 11'h001;
         end else begin
            TRACK_LOCKED_O <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // frame timing: one bit per clock, bit clock toggles each cycle
   // ----------------------------------------------------------------
   reg  [3:0] bit_reg;
   wire       frame_end;

   assign frame_end = (bit_reg == `FCR_BIT_LAST);

   always @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         // start on a frame end so the first frame is a whole one
         bit_reg     <= `FCR_BIT_LAST;
         BIT_CLK_O   <= 1'b0;
         FRAME_CLK_O <= 1'b0;
      end else if (!LVDS_EN_O) begin
         bit_reg     <= `FCR_BIT_LAST;
         BIT_CLK_O   <= 1'b0;
         FRAME_CLK_O <= 1'b0;
      end else begin
         bit_reg     <= frame_end ? 4'h0 : bit_reg + 4'h1;
         // six bit clock periods carry twelve bits per frame
         BIT_CLK_O   <= ~BIT_CLK_O;
         FRAME_CLK_O <= frame_end | (bit_reg < `FCR_HALF_BITS - 4'h1);
      end
   end

   // ----------------------------------------------------------------
   // conversion pipeline and serializer
   // ----------------------------------------------------------------
   reg  [95:0] pipe [0:`FCR_PIPE_DEPTH-1];
   reg  [95:0] ser_reg;
   reg  [95:0] load_word;
   reg  [95:0] shift_word;
   wire [1:0]  src_sel;
   integer     c;
   integer     p;

   assign src_sel = regs[`FCR_A_OUT_CTL][`FCR_ATP_HI:0];

   always @* begin
      load_word  = 96'h0;
      shift_word = 96'h0;
      for (c = 0; c < 8; c = c + 1) begin
         case (src_sel)
            `FCR_SRC_ADC: begin
               load_word[12*c +: 12] = pipe[`FCR_PIPE_DEPTH-1][12*c +: 12];
            end
            `FCR_SRC_ONE: load_word[12*c +: 12] = regs[`FCR_A_PAT_ONE];
            `FCR_SRC_TWO: load_word[12*c +: 12] = regs[`FCR_A_PAT_TWO];
            default: begin
               load_word[12*c +: 12] = c[0] ? regs[`FCR_A_PAT_TWO]
                                            : regs[`FCR_A_PAT_ONE];
            end
         endcase
         // a powered-down adc lane sends zeros when live adc data is selected
         if (ADC_PD_O[c] && src_sel == `FCR_SRC_ADC) begin
            load_word[12*c +: 12] = 12'h000;
         end
         shift_word[12*c +: 12] = {ser_reg[12*c +: 11], 1'b0};
      end
   end

   always @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ser_reg <= 96'h0;
         for (p = 0; p < `FCR_PIPE_DEPTH; p = p + 1) begin
            pipe[p] <= 96'h0;
         end
      end else if (!LVDS_EN_O) begin
         ser_reg <= 96'h0;
      end else if (frame_end) begin
         // five whole frames plus one frame of serial shift
         pipe[0] <= ADC_DATA_I;
         for (p = 1; p < `FCR_PIPE_DEPTH; p = p + 1) begin
            pipe[p] <= pipe[p-1];
         end
         ser_reg <= load_word;
      end else begin
         ser_reg <= shift_word;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_lane
         assign DOUT_O[g] = ser_reg[12*g + 11];
      end
   endgenerate

endmodule // fcr_bank
`default_nettype wire

// ---- fcr_bank_bench.sv ----
// self-checking bench for the front-end control register bank
`default_nettype none
module fcr_bank_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, sck, cs_n, sdi, sdo, tpin;
   logic [5:0]  tcode, cdly, ddly, fcode;
   logic [95:0] adc;
   logic [7:0]  adc_pd, front_pd, lna_on, gm_on, dout;
   logic [2:0]  swing;
   logic [1:0]  pga, tofs;
   logic [3:0]  tfine;
   logic        cw_sw, pll_en, lvds_en, fbsw, pgain, bias;
   logic        ton, tlock, bclk, frame_clock;
   int          failures, samples_checked, cyc;

   fcr_bank i_dut (
      .REF_CLK_I(clk), .RST_N_I(rst_n), .SPI_SCK_I(sck),
      .SPI_CS_N_I(cs_n), .SPI_SDI_I(sdi), .SPI_SDO_O(sdo),
      .TRACK_PIN_I(tpin), .TRACK_CODE_I(tcode), .ADC_DATA_I(adc),
      .ADC_PD_O(adc_pd), .FRONT_PD_O(front_pd), .LNA_ON_O(lna_on),
      .GM_ON_O(gm_on), .CW_SW_ON_O(cw_sw), .PLL_EN_O(pll_en),
      .LVDS_EN_O(lvds_en), .LVDS_SWING_O(swing), .CLK_DLY_O(cdly),
      .DATA_DLY_O(ddly), .FB_SWITCH_O(fbsw), .PREAMP_GAIN_O(pgain),
      .PGA_GAIN_O(pga), .EXT_BIAS_O(bias), .TRACK_OFS_O(tofs),
      .TRACK_FINE_O(tfine), .TRACK_ON_O(ton), .TRACK_LOCKED_O(tlock),
      .FILTER_CODE_O(fcode), .BIT_CLK_O(bclk), .FRAME_CLK_O(frame_clock),
      .DOUT_O(dout));
   fcr_host_model i_host (.clk_i(clk), .sck_o(sck), .cs_n_o(cs_n),
      .sdi_o(sdi), .sdo_i(sdo));

   // --------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      logic [11:0] q;
      i_host.xfer({a, d}, q);
   endtask
   // every frame writes, so a read rewrites the select register
   task automatic rd(input logic [3:0] a, output logic [11:0] q);
      i_host.xfer({4'hf, a, 8'h00}, q);
      i_host.xfer({4'hf, a, 8'h00}, q);
   endtask
   function automatic logic [7:0] gm_exp(input logic [47:0] s);
      for (int k = 0; k < 4; k++) begin
         gm_exp[2*k] = s[12*k+5];
         gm_exp[2*k+1] = s[12*k+11];
      end
   endfunction
   function automatic logic [11:0] lane_exp(input int k,
         input logic [1:0] s, input logic [11:0] p1, p2, pd);
      case (s)
         2'h1: lane_exp = p1;
         2'h2: lane_exp = p2;
         2'h3: lane_exp = k[0] ? p2 : p1;
         default: lane_exp = pd[k] ? 12'h000 : adc[12*k+:12];
      endcase
   endfunction
   task automatic grab(output logic [95:0] v);
      @(posedge frame_clock);
      for (int b = 0; b < 12; b++) begin
         @(negedge clk);
         for (int n = 0; n < 8; n++)
            v[12*n+11-b] = dout[n];
      end
   endtask

   // --------------------------------------------------------------
   // clock and timeout
   // --------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         end_sim();
      end
   end

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      logic [11:0] d, q, p1, p2, r9;
      logic [47:0] sw;
      logic [95:0] v;
      int n;
      {rst_n, tpin, tcode} = '0;
      adc = '0;
      void'($urandom(32'hdfe417da));
      adc = {32'($urandom), 32'($urandom), 32'($urandom)};
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk({adc_pd, front_pd, lna_on, gm_on}, 32'h0000ff00);
      chk({pll_en, lvds_en, cw_sw, swing, cdly, ddly, fcode, ton},
          32'h01800000);
      for (int k = 0; k < 3; k++) begin
         rd(4'h9 + 4'(2 * k), q);
         chk(q, 12'h000);
      end
      wr(4'h7, 12'h020);
      wr(4'h7, 12'h000);
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? 12'hfff : 12'($urandom);
         wr(4'h9, d);
         wr(4'hb, d);
         wr(4'hd, d);
         wr(4'h7, d & 12'hfdf);
         chk(adc_pd, d[7:0]);
         chk(swing, d[11:9]);
         chk(cdly, d[11:6]);
         chk({fbsw, pgain, pga, tofs, bias}, {d[3:0], d[9:8], d[6]});
         for (int k = 0; k < 3; k++) begin
            rd(4'h9 + 4'(2 * k), q);
            chk(q, d);
         end
         rd(4'h7, q);
         chk(q, d & 12'hfdf);
      end
      r9 = d;
      // wave mode: switch registers only count once the mode bit is set
      sw = {16'($urandom), 32'($urandom)};
      for (int k = 0; k < 4; k++)
         wr(4'(k + 2), sw[12*k+:12]);
      d = 12'($urandom) & 12'h0ff;
      wr(4'h6, d);
      chk({front_pd, lna_on}, {d[7:0], ~d[7:0]});
      chk({gm_on, cw_sw, pll_en}, 10'h001);
      wr(4'h6, d | 12'h100);
      chk({pll_en, lvds_en, adc_pd}, 10'h0ff);
      chk({gm_on, lna_on, cw_sw}, {gm_exp(sw), gm_exp(sw), |gm_exp(sw)});
      wr(4'h7, 12'h00c);
      chk({fbsw, pgain}, 2'h3);
      wr(4'h6, 12'h000);
      wr(4'h9, r9);
      // filter: direct code, then tracking by bit and by pin
      d = 12'($urandom);
      wr(4'h8, {2'h0, 1'b1, d[3:0], 1'b0, d[7:4]});
      chk({fcode, tfine}, {d[3:0], 2'h0, d[7:4]});
      wr(4'h7, 12'h100);
      wr(4'h8, {8'h00, d[7:4]});
      tcode = 6'($urandom);
      wr(4'h7, 12'h120);
      chk({ton, fcode}, {1'b1, tcode});
      n = 0;
      while (tlock !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk({tlock, n > 1200}, 2'h3);
      wr(4'h7, 12'h100);
      chk({ton, tlock}, 2'h0);
      tpin = 1'b1;
      tcode = ~tcode;
      repeat (8) @(negedge clk);
      chk({ton, fcode}, {1'b1, tcode});
      tpin = 1'b0;
      repeat (8) @(negedge clk);
      d[5:0] = tcode;
      tcode = ~tcode;
      repeat (8) @(negedge clk);
      chk(fcode, d[5:0]);
      // lanes: every source code, live data first, each flushed by 7 frames
      p1 = 12'($urandom);
      p2 = 12'($urandom);
      wr(4'ha, p1);
      wr(4'hc, p2);
      for (int s = 0; s < 4; s++) begin
         d = {6'($urandom), 4'h0, 2'(s)};
         wr(4'he, d);
         chk(ddly, d[11:6]);
         repeat (7) @(posedge frame_clock);
         grab(v);
         for (int k = 0; k < 8; k++)
            chk(v[12*k+:12], lane_exp(k, 2'(s), p1, p2, r9));
      end
      end_sim();
   end
endmodule // fcr_bank_bench
`default_nettype wire

// ---- fcr_bank_chk.sv ----
// port assertions for the front-end control register bank
`default_nettype none
module fcr_bank_chk (
   input wire logic        REF_CLK_I,      // clock
   input wire logic        RST_N_I,        // reset, active low
   input wire logic        SPI_CS_N_I,     // serial select
   input wire logic [5:0]  TRACK_CODE_I,   // tracking code
   input wire logic [7:0]  ADC_PD_O,       // adc power down
   input wire logic [7:0]  LNA_ON_O,       // lna on
   input wire logic [7:0]  GM_ON_O,        // gm amp on
   input wire logic        CW_SW_ON_O,     // switch powered
   input wire logic        PLL_EN_O,       // pll enable
   input wire logic        LVDS_EN_O,      // lvds enable
   input wire logic        TRACK_ON_O,     // tracking running
   input wire logic        TRACK_LOCKED_O, // lock time elapsed
   input wire logic [5:0]  FILTER_CODE_O,  // filter code
   input wire logic        BIT_CLK_O,      // bit clock
   input wire logic        FRAME_CLK_O,    // frame clock
   input wire logic [7:0]  DOUT_O          // lanes
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] on_cnt_reg;

   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);

   // --------------------------------------------------------------
   // helper: length of the current tracking run, saturating
   // --------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I)
         on_cnt_reg <= 12'h000;
      else if (!TRACK_ON_O)
         on_cnt_reg <= 12'h000;
      else if (on_cnt_reg != 12'hfff)
         on_cnt_reg <= on_cnt_reg + 12'h001;
   end

   // --------------------------------------------------------------
   // properties
   // --------------------------------------------------------------
   property p_lock_early;
      on_cnt_reg < 12'h4e2 |-> !TRACK_LOCKED_O;
   endproperty
   property p_lock_late;
      TRACK_ON_O && on_cnt_reg > 12'h4e1 |-> TRACK_LOCKED_O;
   endproperty
   property p_frame;
      @(posedge REF_CLK_I) disable iff (!RST_N_I || !LVDS_EN_O)
      $rose(FRAME_CLK_O) |-> FRAME_CLK_O [*6] ##1 !FRAME_CLK_O [*6]
         ##1 FRAME_CLK_O;
   endproperty
   property p_bit_clk;
      LVDS_EN_O [*3] |-> BIT_CLK_O != $past(BIT_CLK_O);
   endproperty
   property p_idle;
      !LVDS_EN_O [*2] |-> DOUT_O == 8'h00 && !BIT_CLK_O && !FRAME_CLK_O;
   endproperty
   property p_cw_off;
      !PLL_EN_O |-> !LVDS_EN_O && ADC_PD_O == 8'hff;
   endproperty
   property p_tgc_gm;
      PLL_EN_O [*2] |-> GM_ON_O == 8'h00 && !CW_SW_ON_O;
   endproperty
   property p_cw_lna;
      !PLL_EN_O [*2] |-> LNA_ON_O == GM_ON_O && CW_SW_ON_O == |GM_ON_O;
   endproperty
   property p_track;
      (TRACK_ON_O && $stable(TRACK_CODE_I)) [*4]
         |-> FILTER_CODE_O == TRACK_CODE_I;
   endproperty
   property p_hold;
      !TRACK_ON_O && $past(!TRACK_ON_O) && SPI_CS_N_I && $past(SPI_CS_N_I)
         |-> $stable(FILTER_CODE_O);
   endproperty

   a_lock_early: assert property (p_lock_early)
      else $error("lock flag raised too early");
   a_lock_late: assert property (p_lock_late)
      else $error("lock flag missing");
   a_frame: assert property (p_frame)
      else $error("frame clock shape wrong");
   a_bit_clk: assert property (p_bit_clk)
      else $error("bit clock not toggling");
   a_idle: assert property (p_idle)
      else $error("lanes active in wave mode");
   a_cw_off: assert property (p_cw_off)
      else $error("wave mode left blocks powered");
   a_tgc_gm: assert property (p_tgc_gm)
      else $error("switch registers acted in time-gain mode");
   a_cw_lna: assert property (p_cw_lna)
      else $error("lna or switch power disagrees with gm");
   a_track: assert property (p_track)
      else $error("filter code not following tracking");
   a_hold: assert property (p_hold)
      else $error("filter code moved while idle");

   c_cw: cover property (!PLL_EN_O);
   c_lock: cover property ($rose(TRACK_LOCKED_O));
   c_frame: cover property ($fell(SPI_CS_N_I));
endmodule // fcr_bank_chk

bind fcr_bank fcr_bank_chk i_chk (
   .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .SPI_CS_N_I(SPI_CS_N_I),
   .TRACK_CODE_I(TRACK_CODE_I), .ADC_PD_O(ADC_PD_O),
   .LNA_ON_O(LNA_ON_O), .GM_ON_O(GM_ON_O), .CW_SW_ON_O(CW_SW_ON_O),
   .PLL_EN_O(PLL_EN_O), .LVDS_EN_O(LVDS_EN_O), .TRACK_ON_O(TRACK_ON_O),
   .TRACK_LOCKED_O(TRACK_LOCKED_O), .FILTER_CODE_O(FILTER_CODE_O),
   .BIT_CLK_O(BIT_CLK_O), .FRAME_CLK_O(FRAME_CLK_O), .DOUT_O(DOUT_O));
`default_nettype wire

// ---- fcr_consts.vh ----
// constants for the front-end control register bank
`ifndef FCR_CONSTS_VH
`define FCR_CONSTS_VH

// ----------------------------------------------------------------
// serial frame
// ----------------------------------------------------------------
`define FCR_DW          12
`define FCR_AW          4
`define FCR_FRAME_BITS  5'h10
`define FCR_SH_RESET    16'h0000

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define FCR_A_CW_FIRST  4'h2
`define FCR_A_MODE      4'h6
`define FCR_A_FRONT     4'h7
`define FCR_A_FILTER    4'h8
`define FCR_A_ADC_PD    4'h9
`define FCR_A_PAT_ONE   4'ha
`define FCR_A_SWING     4'hb
`define FCR_A_PAT_TWO   4'hc
`define FCR_A_CLK_DLY   4'hd
`define FCR_A_OUT_CTL   4'he
`define FCR_A_RB_SEL    4'hf
`define FCR_REG_RESET   12'h000

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FCR_MODE_BIT    8
`define FCR_CW_ON_LO    5
`define FCR_CW_ON_HI    11
`define FCR_PGA_HI      1
`define FCR_GAIN_BIT    2
`define FCR_FBSW_BIT    3
`define FCR_TRACK_BIT   5
`define FCR_BIAS_BIT    6
`define FCR_OFS_HI      9
`define FCR_OFS_LO      8
`define FCR_FINE_HI     3
`define FCR_PR_HI       8
`define FCR_PR_LO       5
`define FCR_CTL_BIT     9
`define FCR_SWING_HI    11
`define FCR_SWING_LO    9
`define FCR_DLY_HI      11
`define FCR_DLY_LO      6
`define FCR_ATP_HI      1
`define FCR_RB_HI       11
`define FCR_RB_LO       8

// ----------------------------------------------------------------
// output source codes and timing
// ----------------------------------------------------------------
`define FCR_SRC_ADC     2'h0
`define FCR_SRC_ONE     2'h1
`define FCR_SRC_TWO     2'h2
`define FCR_BIT_LAST    4'hb
`define FCR_HALF_BITS   4'h6
`define FCR_PIPE_DEPTH  5
// 50 us of tracking at a 40 ns clock
`define FCR_LOCK_CYC    11'h4e2

`endif

// ---- fcr_host_model.sv ----
// host controller model driving the serial configuration port
`default_nettype none
module fcr_host_model (
   input  wire logic clk_i,   // bench clock
   output var  logic sck_o,   // serial clock
   output var  logic cs_n_o,  // frame select, low
   output var  logic sdi_o,   // data to device
   input  wire logic sdo_i    // data from device
);
   timeunit 1ns;
   timeprecision 1ns;

   // serial clock rests low between frames; 8 clk per bit = 320 ns
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      sdi_o = 1'b0;
   end

   task automatic xfer(input logic [15:0] w, output logic [11:0] q);
      logic [15:0] r;
      @(negedge clk_i);
      cs_n_o = 1'b0;
      repeat (4) @(negedge clk_i);
      for (int i = 15; i >= 0; i--) begin
         sdi_o = w[i];
         repeat (4) @(negedge clk_i);
         r[i] = sdo_i;
         sck_o = 1'b1;
         repeat (4) @(negedge clk_i);
         sck_o = 1'b0;
      end
      repeat (4) @(negedge clk_i);
      cs_n_o = 1'b1;
      // released line has no pull: show the inverse of the last bit
      sdi_o = ~sdi_o;
      repeat (4) @(negedge clk_i);
      q = r[11:0];
   endtask
endmodule // fcr_host_model
`default_nettype wire

// ---- fcr_sync2.v ----
// two-flop synchroniser for asynchronous input levels
`default_nettype none
module fcr_sync2 #(
   parameter W = 1
) (
   input  wire         clk_i,    // sampling clock
   input  wire         rst_n_i,  // async reset, active low
   input  wire [W-1:0] d_i,      // asynchronous levels
   output reg  [W-1:0] q_o       // synchronised levels
);
   reg [W-1:0] meta_reg;

   // first stage feeds the second stage only
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= {W{1'b0}};
         q_o      <= {W{1'b0}};
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule // fcr_sync2
`default_nettype wire
